/* File: rtl/wss_count_mem.sv */
// Purpose: Weld count per schedule, one word per schedule.
// Assumes: Synchronous write and registered read.
// Notes: Contents are not reset; software programs them.
`timescale 1ns/1ps
module wss_count_mem
#(
   parameter int unsigned DEPTH = 50,
   parameter int unsigned WIDTH = 14
)
(
   input wire logic core_clk,
   wss_mem_if.mem mp
);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [WIDTH-1:0] rdata_ff;

   always_ff @(posedge core_clk)
   begin
      if (mp.we && (32'(mp.addr) < DEPTH))
      begin
         mem_ff[mp.addr] <= mp.wdata;
      end
      if (mp.re && (32'(mp.addr) < DEPTH))
      begin
         rdata_ff <= mem_ff[mp.addr];
      end
   end

   assign mp.rdata = rdata_ff;
endmodule // wss_count_mem

/* File: rtl/wss_mem_if.sv */
// Purpose: Port between the sequencer and its weld count table.
// Assumes: One access per cycle, read data one cycle after re.
// Notes: Read data comes from a register in the memory.
`timescale 1ns/1ps
interface wss_mem_if;
   logic we;
   logic re;
   logic [5:0] addr;
   logic [13:0] wdata;
   logic [13:0] rdata;
   modport ctl (output we, output re, output addr, output wdata, input rdata);
   modport mem (input we, input re, input addr, input wdata, output rdata);
endinterface

/* File: rtl/wss_pkg.sv */
// Purpose: Shared constants and types for the weld stepper sequencer.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes: Schedules 0..49, five groups of ten.
package wss_pkg;
   localparam int unsigned SCHED_W = 6;
   localparam int unsigned CNT_W = 14;
   localparam int unsigned NSTEP = 5;
   localparam logic [5:0] SCHED_LAST = 6'h31;
   localparam logic [5:0] GROUP_SPAN = 6'h0A;
   localparam logic [5:0] GROUP_TOP = 6'h09;
   localparam logic [13:0] CNT_MAX = 14'h270F;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DIAL = 8'h04;
   localparam logic [7:0] OFS_PANEL = 8'h08;
   localparam logic [7:0] OFS_LAST = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_TABLE = 8'h40;
   // Last table word; it lies past the low byte of the address
   localparam logic [11:0] OFS_TABLE_END = 12'h104;
   // Field positions
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_SEL_LSB = 2;
   localparam int unsigned CTRL_BINOPT = 4;
   localparam int unsigned CTRL_WELD = 5;
   localparam int unsigned PANEL_ENTER = 0;
   localparam int unsigned PANEL_DATA_L = 1;
   localparam int unsigned PANEL_DATA_R = 2;
   localparam int unsigned LAST_LC_LSB = 16;
   localparam int unsigned STAT_BUSY = 8;
   localparam int unsigned STAT_IDX_LSB = 5;
   localparam int unsigned STAT_SCHED_LSB = 16;
   // Reset values
   localparam logic [5:0] CTRL_RST = 6'h20;
   localparam logic [5:0] DIAL_RST = 6'h00;

   typedef enum logic [1:0] {MODE_OFF = 2'h0, MODE_MULTI = 2'h1, MODE_SINGLE = 2'h2, MODE_RSVD = 2'h3}
      wss_mode_t;
   typedef enum logic [1:0] {SEL_INTERNAL = 2'h0, SEL_EXTERNAL = 2'h1, SEL_ANTI = 2'h2, SEL_BINARY = 2'h3}
      wss_sel_t;
   typedef enum {WS_IDLE, WS_RUN, WS_LOAD, WS_RLOAD} wss_fsm_t;
endpackage

/* File: rtl/wss_sequencer.sv */
// Purpose: Weld-count stepper: picks the stepper, starts sequences, counts welds.
// Assumes: Initiation and select inputs are synchronous to core_clk.
// Notes: Counts live in a table reached over APB; one sequence at a time.
// Operation
// - last step kept in group, or 00..49
// - last step is start step; reset reloads
// - last count 0000..9999, start count, reloaded
// - finished stepper stops welding, shows end
// - internal: primary starts dialed schedule's stepper
// - internal: second starts B, third starts C
// - external: second/third pick A..D, primary starts
// - anti-tie-down: second and third together start
// - binary option: select bits pick A..E
// - single mode counts only counting initiations
// - single mode: second runs 10, third 20
// - single binary: second runs selected schedule
// - enter plus both data buttons resets stepper
// - steppers start at 00,10,20,30,40
// - decrement only when a weld was made
// - mode code: off, multiple, single stepper
// - single mode: zero count marks the end
`timescale 1ns/1ps
module wss_sequencer
import wss_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic primary_initiate_input,
   input wire logic second_initiate_input,
   input wire logic third_initiate_input,
   input wire logic select_bit_one,
   input wire logic select_bit_two,
   input wire logic select_bit_four,
   input wire logic select_bit_eight,
   input wire logic seq_done,
   input wire logic weld_made,
   output logic seq_start,
   output logic [wss_pkg::SCHED_W-1:0] seq_schedule,
   output logic seq_counted,
   output logic [wss_pkg::NSTEP-1:0] end_of_stepper
);
   import wss_pkg::*;

   typedef struct packed {
      wss_fsm_t fsm;
      logic [5:0] ctrl;
      logic [5:0] dial;
      logic rst_req;
      logic rd_pend;
      logic pri_q;
      logic sec_q;
      logic thr_q;
      logic [NSTEP-1:0][5:0] ls;
      logic [NSTEP-1:0][13:0] lc;
      logic [NSTEP-1:0] endf;
      logic [2:0] idx;
      logic counted;
      logic start;
      logic [5:0] sched;
   } wss_state_t;

   wss_state_t st_ff;
   wss_state_t nxt_st;
   wss_mem_if mif ();

   function automatic logic [5:0] first_sched(input logic [2:0] i);
      first_sched = 6'({3'h0, i} * GROUP_SPAN);
   endfunction

   function automatic logic [2:0] group_of(input logic [5:0] s);
      group_of = 3'(s / GROUP_SPAN);
   endfunction

   // Returns {valid, stepper}; more than one closed bit is invalid
   function automatic logic [3:0] bin_pick(input logic [3:0] b);
      unique case (b)
         4'h0: bin_pick = 4'h8;
         4'h1: bin_pick = 4'h9;
         4'h2: bin_pick = 4'hA;
         4'h4: bin_pick = 4'hB;
         4'h8: bin_pick = 4'hC;
         default: bin_pick = 4'h0;
      endcase
   endfunction

   wss_mode_t mode;
   wss_sel_t sel;
   logic binopt, weld_ok, pri_r, sec_r, thr_r, both_r, go, gcnt, fsm_re;
   logic [2:0] gidx, tgt;
   logic [3:0] bsel;
   logic [5:0] gsched, nls;
   logic [7:0] aofs;
   logic acc, tbl;

   wss_count_mem #(.DEPTH(50), .WIDTH(CNT_W)) u_mem (.core_clk(core_clk), .mp(mif.mem));

   assign mode = wss_mode_t'(st_ff.ctrl[CTRL_MODE_LSB +: 2]);
   assign sel = wss_sel_t'(st_ff.ctrl[CTRL_SEL_LSB +: 2]);
   assign binopt = st_ff.ctrl[CTRL_BINOPT];
   assign weld_ok = weld_made && st_ff.ctrl[CTRL_WELD];
   assign pri_r = primary_initiate_input && !st_ff.pri_q;
   assign sec_r = second_initiate_input && !st_ff.sec_q;
   assign thr_r = third_initiate_input && !st_ff.thr_q;
   assign both_r = second_initiate_input && third_initiate_input && !(st_ff.sec_q && st_ff.thr_q);
   assign bsel = bin_pick({select_bit_eight, select_bit_four, select_bit_two, select_bit_one});
   assign tgt = (mode == MODE_SINGLE) ? 3'h0 : group_of(st_ff.dial);
   assign aofs = paddr[7:0];
   assign acc = psel && penable;
   assign tbl = (paddr >= 12'(OFS_TABLE)) && (paddr <= OFS_TABLE_END) && (paddr[1:0] == 2'h0);

   // Stepper choice for an initiation edge
   always_comb
   begin
      go = 1'b0;
      gcnt = 1'b0;
      gidx = 3'h0;
      gsched = 6'h00;
      unique case (sel)
         SEL_INTERNAL:
         begin
            if (pri_r)
            begin
               go = 1'b1;
               gcnt = 1'b1;
               gidx = group_of(st_ff.dial);
            end
            else if (sec_r)
            begin
               go = 1'b1;
               gidx = 3'h1;
            end
            else if (thr_r)
            begin
               go = 1'b1;
               gidx = 3'h2;
            end
         end
         SEL_EXTERNAL:
         begin
            go = pri_r;
            gcnt = 1'b1;
            gidx = {1'b0, third_initiate_input, second_initiate_input};
         end
         SEL_ANTI:
         begin
            go = both_r;
            gcnt = 1'b1;
            gidx = group_of(st_ff.dial);
         end
         SEL_BINARY:
         begin
            go = (pri_r || (sec_r && mode == MODE_SINGLE)) && binopt && bsel[3];
            gcnt = pri_r;
            gidx = bsel[2:0];
         end
      endcase
      if (mode == MODE_SINGLE)
      begin
         if (gcnt)
         begin
            gidx = 3'h0;
            gsched = st_ff.ls[0];
         end
         else
         begin
            gsched = first_sched(gidx);
         end
      end
      else if (mode == MODE_MULTI)
      begin
         gsched = st_ff.ls[gidx];
         gcnt = 1'b1;
      end
      else
      begin
         go = pri_r;
         gcnt = 1'b0;
         gsched = st_ff.dial;
      end
      if (gcnt && st_ff.endf[gidx])
      begin
         go = 1'b0;
      end
   end

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.start = 1'b0;
      nxt_st.pri_q = primary_initiate_input;
      nxt_st.sec_q = second_initiate_input;
      nxt_st.thr_q = third_initiate_input;
      fsm_re = 1'b0;
      mif.re = 1'b0;
      mif.we = 1'b0;
      mif.addr = 6'h00;
      mif.wdata = pwdata[CNT_W-1:0];
      nls = st_ff.ls[st_ff.idx] + 6'h01;
      unique case (st_ff.fsm)
         WS_IDLE:
         begin
            if (st_ff.rst_req)
            begin
               nxt_st.rst_req = 1'b0;
               nxt_st.idx = tgt;
               fsm_re = 1'b1;
               mif.addr = first_sched(tgt);
               nxt_st.fsm = WS_RLOAD;
            end
            else if (go)
            begin
               nxt_st.start = 1'b1;
               nxt_st.sched = gsched;
               nxt_st.counted = gcnt;
               nxt_st.idx = gidx;
               nxt_st.fsm = WS_RUN;
            end
         end
         WS_RUN:
         begin
            if (seq_done)
            begin
               nxt_st.fsm = WS_IDLE;
               if (st_ff.counted && weld_ok)
               begin
                  if (st_ff.lc[st_ff.idx] > 14'h0001)
                  begin
                     nxt_st.lc[st_ff.idx] = st_ff.lc[st_ff.idx] - 14'h0001;
                  end
                  else
                  begin
                     nxt_st.lc[st_ff.idx] = 14'h0000;
                     if ((mode == MODE_SINGLE) ? (st_ff.ls[0] >= SCHED_LAST) :
                         (st_ff.ls[st_ff.idx] >= first_sched(st_ff.idx) + GROUP_TOP))
                     begin
                        nxt_st.endf[st_ff.idx] = 1'b1;
                     end
                     else
                     begin
                        nxt_st.ls[st_ff.idx] = nls;
                        fsm_re = 1'b1;
                        mif.addr = nls;
                        nxt_st.fsm = WS_LOAD;
                     end
                  end
               end
            end
         end
         WS_LOAD:
         begin
            nxt_st.lc[st_ff.idx] = mif.rdata;
            if (mode == MODE_SINGLE && mif.rdata == 14'h0000)
            begin
               nxt_st.endf[st_ff.idx] = 1'b1;
            end
            nxt_st.fsm = WS_IDLE;
         end
         WS_RLOAD:
         begin
            nxt_st.ls[st_ff.idx] = first_sched(st_ff.idx);
            nxt_st.lc[st_ff.idx] = mif.rdata;
            nxt_st.endf[st_ff.idx] = 1'b0;
            nxt_st.fsm = WS_IDLE;
         end
      endcase
      mif.re = fsm_re;

      // APB slave; the table port goes to the stepper first
      pready = acc;
      pslverr = 1'b0;
      prdata = 32'h0000_0000;
      if (acc && tbl)
      begin
         if (pwrite)
         begin
            pready = !fsm_re;
            // counts above 9999 never enter the table
            if (!fsm_re && pwdata[CNT_W-1:0] <= CNT_MAX)
            begin
               mif.we = 1'b1;
               mif.addr = 6'((paddr - 12'(OFS_TABLE)) >> 2);
            end
         end
         else if (st_ff.rd_pend)
         begin
            nxt_st.rd_pend = 1'b0;
            prdata = {18'h00000, mif.rdata};
         end
         else
         begin
            pready = 1'b0;
            if (!fsm_re)
            begin
               mif.re = 1'b1;
               mif.addr = 6'((paddr - 12'(OFS_TABLE)) >> 2);
               nxt_st.rd_pend = 1'b1;
            end
         end
      end
      else if (acc)
      begin
         unique case ({paddr[11:8], aofs})
            {4'h0, OFS_CTRL}: prdata = {26'h0, st_ff.ctrl};
            {4'h0, OFS_DIAL}: prdata = {26'h0, st_ff.dial};
            {4'h0, OFS_PANEL}: prdata = 32'h0000_0000;
            {4'h0, OFS_LAST}: prdata = {2'h0, st_ff.lc[tgt], 10'h000, st_ff.ls[tgt]};
            {4'h0, OFS_STATUS}: prdata = {10'h000, st_ff.sched, 7'h00, st_ff.fsm != WS_IDLE, st_ff.idx,
               st_ff.endf};
            default: pslverr = 1'b1;
         endcase
         if (pwrite)
         begin
            unique case ({paddr[11:8], aofs})
               {4'h0, OFS_CTRL}: nxt_st.ctrl = pwdata[5:0];
               {4'h0, OFS_DIAL}:
               begin
                  if (pwdata[5:0] <= SCHED_LAST && pwdata[31:6] == 26'h0)
                  begin
                     nxt_st.dial = pwdata[5:0];
                  end
               end
               {4'h0, OFS_PANEL}:
               begin
                  // enter held with both data buttons
                  if (pwdata[PANEL_ENTER] && pwdata[PANEL_DATA_L] && pwdata[PANEL_DATA_R])
                  begin
                     nxt_st.rst_req = 1'b1;
                  end
               end
               {4'h0, OFS_LAST}:
               begin
                  if ((mode == MODE_SINGLE) ? (pwdata[5:0] <= SCHED_LAST) : (group_of(pwdata[5:0]) == tgt
                      && pwdata[5:0] <= SCHED_LAST))
                  begin
                     nxt_st.ls[tgt] = pwdata[5:0];
                  end
                  if (pwdata[LAST_LC_LSB +: CNT_W] <= CNT_MAX)
                  begin
                     nxt_st.lc[tgt] = pwdata[LAST_LC_LSB +: CNT_W];
                  end
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_ff <= '{fsm: WS_IDLE, ctrl: CTRL_RST, dial: DIAL_RST, ls: {6'h28, 6'h1E, 6'h14, 6'h0A, 6'h00},
            default: '0};
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign seq_start = st_ff.start;
   assign seq_schedule = st_ff.sched;
   assign seq_counted = st_ff.counted;
   assign end_of_stepper = st_ff.endf;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   chk_ls_in_group: assert property (mode == MODE_MULTI |-> group_of(st_ff.ls[st_ff.idx]) == st_ff.idx)
      else $error("last step left its group");
   chk_start_step: assert property (go && gcnt && !st_ff.rst_req && st_ff.fsm == WS_IDLE |=>
      seq_start && seq_schedule == $past(gsched) && seq_counted)
      else $error("sequence did not start at last step");
   chk_count_range: assert property (st_ff.lc[st_ff.idx] <= CNT_MAX)
      else $error("last count above 9999");
   chk_end_blocks: assert property (seq_start && seq_counted |-> !st_ff.endf[st_ff.idx])
      else $error("finished stepper started");
   chk_second_b: assert property (st_ff.fsm == WS_IDLE && !st_ff.rst_req && mode == MODE_MULTI &&
      sel == SEL_INTERNAL && sec_r && !pri_r && !st_ff.endf[1] |=> seq_start && group_of(seq_schedule) == 3'h1)
      else $error("second input did not start stepper B");
   chk_single_nocount: assert property (st_ff.fsm == WS_IDLE && !st_ff.rst_req && mode == MODE_SINGLE &&
      sel == SEL_INTERNAL && thr_r && !pri_r && !sec_r |=> seq_start && seq_schedule == 6'h14 && !seq_counted)
      else $error("third input in single mode wrong");
   chk_count_dec: assert property (st_ff.fsm == WS_RUN && seq_done && st_ff.counted && weld_ok &&
      st_ff.lc[st_ff.idx] > 14'h0001 |=> st_ff.lc[st_ff.idx] == $past(st_ff.lc[st_ff.idx]) - 14'h0001)
      else $error("weld count not decremented");
   chk_no_weld_hold: assert property (st_ff.fsm == WS_RUN && seq_done && !weld_ok |=>
      $stable(st_ff.lc) && $stable(st_ff.ls))
      else $error("count moved without a weld");
   chk_reset_reload: assert property (st_ff.fsm == WS_RLOAD |=> st_ff.ls[$past(st_ff.idx)] ==
      first_sched($past(st_ff.idx)) && !st_ff.endf[$past(st_ff.idx)] && st_ff.fsm == WS_IDLE)
      else $error("stepper reset did not reload");
   chk_off_nocount: assert property (mode == MODE_OFF && seq_start |-> !seq_counted)
      else $error("disabled stepper counted");

   cov_start: cover property (seq_start && seq_counted);
   cov_end: cover property ($rose(st_ff.endf[0]));
   cov_step_load: cover property (st_ff.fsm == WS_LOAD);
   cov_table_read: cover property (acc && tbl && !pwrite && pready);
endmodule // wss_sequencer

/* File: test/wss_sequencer_bench.sv */
// Purpose: Self-checking bench for the weld stepper sequencer.
// Assumes: APB master on core_clk; engine model answers every start.
// Notes: Multi-mode selection tests run with welds off so step positions stay put.
`timescale 1ns/1ps
module wss_sequencer_bench;
   import wss_pkg::*;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] pins = 3'h0;
   logic [3:0] sel_bits = 4'h0;
   logic weld_en = 1'b1;
   logic [3:0] delay = 4'h2;
   logic seq_done;
   logic weld_made;
   logic seq_start;
   logic [5:0] seq_schedule;
   logic seq_counted;
   logic [4:0] end_of_stepper;
   logic [31:0] q;
   logic e;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int k;

   always #2.5 core_clk = ~core_clk;

   wss_sequencer uut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .primary_initiate_input(pins[0]), .second_initiate_input(pins[1]), .third_initiate_input(pins[2]),
      .select_bit_one(sel_bits[0]), .select_bit_two(sel_bits[1]), .select_bit_four(sel_bits[2]),
      .select_bit_eight(sel_bits[3]), .seq_done(seq_done), .weld_made(weld_made), .seq_start(seq_start),
      .seq_schedule(seq_schedule), .seq_counted(seq_counted), .end_of_stepper(end_of_stepper));

   wss_weld_engine eng (.core_clk(core_clk), .nrst(nrst), .seq_start(seq_start), .weld_en(weld_en),
      .delay(delay), .seq_done(seq_done), .weld_made(weld_made));

   task automatic finish_test;
      $display("TB: errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         errors++;
         $display("unexpected at %0t: run too long", $time);
         finish_test;
      end
   end

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: word %h, want %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: bit %b, want %b", $time, got, exp);
      end
   endtask

   function automatic logic [11:0] tab(input int n);
      return 12'(32'h40 + 4 * n);
   endfunction

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge core_clk);
      end
      while (pready !== 1'b1);
      check_bit(pready, 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check_word(q, exp);
   endtask

   task automatic last(input logic [5:0] s, input logic [13:0] c);
      rd({4'h0, OFS_LAST}, {2'h0, c, 10'h0, s});
   endtask

   // Reload needs two more edges after the write lands
   task automatic panel;
      wr({4'h0, OFS_PANEL}, 32'h7);
      repeat (3) @(posedge core_clk);
   endtask

   task automatic start(input logic [2:0] p, input logic [5:0] s, input logic c);
      int n;
      @(posedge core_clk);
      pins <= p;
      for (n = 0; n < 12 && seq_start !== 1'b1; n++)
      begin
         @(posedge core_clk);
         #1;
      end
      check_bit(seq_start, 1'b1);
      check_word({26'h0, seq_schedule}, {26'h0, s});
      check_bit(seq_counted, c);
      for (n = 0; n < 40 && seq_done !== 1'b1; n++)
      begin
         @(posedge core_clk);
         #1;
      end
      repeat (4) @(posedge core_clk);
      pins <= 3'h0;
      repeat (3) @(posedge core_clk);
   endtask

   task automatic no_start(input logic [2:0] p);
      @(posedge core_clk);
      pins <= p;
      repeat (8)
      begin
         @(posedge core_clk);
         #1;
         check_bit(seq_start, 1'b0);
      end
      @(posedge core_clk);
      pins <= 3'h0;
      repeat (3) @(posedge core_clk);
   endtask

   initial
   begin
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      rd({4'h0, OFS_CTRL}, 32'h20);
      rd({4'h0, OFS_DIAL}, 32'h0);
      last(6'h00, 14'h0);
      apb(1'b0, 12'h014, 32'h0);
      check_bit(e, 1'b1);
      start(3'h1, 6'h00, 1'b0);
      for (k = 0; k < 50; k++)
         wr(tab(k), 32'(k + 1));
      rd(tab(5), 32'h6);
      wr({4'h0, OFS_DIAL}, 32'h32);
      rd({4'h0, OFS_DIAL}, 32'h0);
      wr({4'h0, OFS_CTRL}, 32'h21);
      panel;
      last(6'h00, 14'h1);
      start(3'h1, 6'h00, 1'b1);
      last(6'h01, 14'h2);
      weld_en <= 1'b0;
      delay <= 4'h9;
      start(3'h1, 6'h01, 1'b1);
      last(6'h01, 14'h2);
      panel;
      start(3'h2, 6'h0A, 1'b1);
      start(3'h4, 6'h14, 1'b1);
      wr({4'h0, OFS_DIAL}, 32'h19);
      start(3'h1, 6'h14, 1'b1);
      wr({4'h0, OFS_DIAL}, 32'h0);
      wr({4'h0, OFS_CTRL}, 32'h25);
      for (k = 0; k < 4; k++)
         start({k[1:0], 1'b1}, 6'(10 * k), 1'b1);
      wr({4'h0, OFS_CTRL}, 32'h3D);
      for (k = 0; k < 5; k++)
      begin
         sel_bits <= (k == 0) ? 4'h0 : 4'(1 << (k - 1));
         start(3'h1, 6'(10 * k), 1'b1);
      end
      sel_bits <= 4'h3;
      no_start(3'h1);
      wr({4'h0, OFS_CTRL}, 32'h29);
      start(3'h6, 6'h00, 1'b1);
      no_start(3'h2);
      wr({4'h0, OFS_CTRL}, 32'h21);
      weld_en <= 1'b1;
      delay <= 4'h2;
      wr({4'h0, OFS_LAST}, 32'h2710000C);
      last(6'h00, 14'h1);
      wr({4'h0, OFS_LAST}, 32'h00010009);
      last(6'h09, 14'h1);
      start(3'h1, 6'h09, 1'b1);
      check_word({27'h0, end_of_stepper}, 32'h1);
      no_start(3'h1);
      panel;
      check_word({27'h0, end_of_stepper}, 32'h0);
      wr({4'h0, OFS_CTRL}, 32'h22);
      panel;
      start(3'h2, 6'h0A, 1'b0);
      start(3'h4, 6'h14, 1'b0);
      last(6'h00, 14'h1);
      start(3'h1, 6'h00, 1'b1);
      last(6'h01, 14'h2);
      wr(tab(46), 32'h0);
      wr({4'h0, OFS_LAST}, 32'h0001002D);
      last(6'h2D, 14'h1);
      start(3'h1, 6'h2D, 1'b1);
      check_word({27'h0, end_of_stepper}, 32'h1);
      rd({4'h0, OFS_STATUS}, 32'h002D0001);
      wr({4'h0, OFS_CTRL}, 32'h3E);
      panel;
      sel_bits <= 4'h2;
      start(3'h2, 6'h14, 1'b0);
      finish_test;
   end
endmodule // wss_sequencer_bench

/* File: test/wss_weld_engine.sv */
// Purpose: Weld sequence engine stand-in facing the sequencer.
// Assumes: One sequence at a time, each started by seq_start.
// Notes: weld_made means nothing outside seq_done, so it shows the inverse there.
`timescale 1ns/1ps
module wss_weld_engine
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic seq_start,
   input wire logic weld_en,
   input wire logic [3:0] delay,
   output logic seq_done,
   output logic weld_made
);
   logic [3:0] cnt_ff;
   // Delay of at least two keeps done clear of the start pulse
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         cnt_ff <= 4'h0;
      else if (seq_start)
         cnt_ff <= delay;
      else if (cnt_ff != 4'h0)
         cnt_ff <= cnt_ff - 4'h1;
   end
   assign seq_done = (cnt_ff == 4'h1);
   assign weld_made = seq_done ? weld_en : !weld_en;
endmodule // wss_weld_engine
